// ### char_sync_defines.svh
// register offsets, field positions, the control reset value and line constants
// assumes a 32-bit register bus with word-aligned byte addresses
`ifndef CHAR_SYNC_DEFINES_SVH
`define CHAR_SYNC_DEFINES_SVH
// ------------------------------------------------------------
// register word indices (byte address = index * 4)
// ------------------------------------------------------------
`define IDX_CTRL 3'h0
`define IDX_SYNC 3'h1
`define IDX_DROPA 3'h2
`define IDX_DROPB 3'h3
`define IDX_LIMIT 3'h4
`define IDX_STOP 3'h5
`define IDX_STATUS 3'h6
`define IDX_TXCHR 3'h7
// ------------------------------------------------------------
// control and drop-mask field positions
// ------------------------------------------------------------
`define F_MODE 1:0
`define F_CODE 3:2
`define F_PAR 5:4
`define F_ERRCHK 6
`define F_IDLES 7
`define F_MSB 8
`define F_SUPP 9
`define F_SHIFT 12:10
`define F_BCC 14:13
`define F_DMASK 30:24
`define CTRL_RST 32'h0000000c
// ------------------------------------------------------------
// line and bus constants
// ------------------------------------------------------------
`define MIN_W 4'h5
`define FULL_W 4'h8
`define SYNC_CMP_BITS 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### char_sync_pkg.sv
// types shared by the character sync receiver
// assumes nothing beyond a SystemVerilog tool
package char_sync_pkg;
   // ------------------------------------------------------------
   // line modes, parity choices and framer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SYNC = 2'b00,
      MODE_MONO = 2'b01,
      MODE_ASYNC = 2'b10,
      MODE_RSVD = 2'b11
   } mode_t;
   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ODD = 2'b10,
      PAR_IGNORE = 2'b11
   } parity_t;
   typedef enum logic [2:0] {
      ST_HUNT = 3'b000,
      ST_OUTSIDE = 3'b001,
      ST_INTEXT = 3'b010,
      ST_BCC = 3'b011,
      ST_DRAIN = 3'b100
   } state_t;
endpackage : char_sync_pkg

// ### char_sync_hunt_drop.sv
// character-oriented sync receiver: hunt, capture, drop sync
// assumes an AXI4-Lite master on clk and a slow line clock pin
//
// Notes on behaviour
// - short codes keep programmed match parity bit
// - 8-bit codes force match parity to setting
// - 8-bit plus parity with two syncs compares last 16 bits
// - capture starts after one or two syncs
// - idle is all ones, sync-on-idles option
// - drop list: one within, six outside chars
// - within char searched only inside checked text
// - no error check means all outside text
// - within char wins over stop chars
// - with checking, drop after block check chars
// - drop N chars after match or BCC
// - zero count, empty list never drops
// - drop logic only in synchronous modes
// - after drop, stop capture and hunt
// - outside idles are not captured unless count and list are empty
// - frame is code width plus parity bit
// - transmit ignore parity zero, or odd for 8
// - no bit shift for MSB first or suppress
// - bit shift moves through data bits only
// - check span after start, includes stop char
// - fourth stop char keeps receiver in sync
//
// Chosen here: the AXI4-Lite slave port and the address map.
`include "char_sync_defines.svh"
`timescale 1ns/100ps
module char_sync_hunt_drop
   import char_sync_pkg::*;
#(
   parameter int ADDR_W = 5,
   parameter int SHR_W = 18
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_clk,
   input wire logic line_data,
   output logic [8:0] char_data,
   output logic char_valid,
   output logic char_checked,
   output logic in_sync,
   output logic sync_lost
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W != 5) begin : g_bad_addr
      $error("ADDR_W must be 5");
   end
   if (SHR_W != 18) begin : g_bad_shr
      $error("SHR_W must be 18");
   end

   // ------------------------------------------------------------
   // match character framing
   // ------------------------------------------------------------
   function automatic logic [8:0] match_frame(input logic [7:0] c,
         input logic [3:0] w, input parity_t p);
      logic [8:0] f;
      f = {1'b0, c};
      if (w == `FULL_W && p != PAR_NONE) begin
         f[8] = (p == PAR_EVEN) ? ^c : ~^c;
      end
      // shorter codes keep bit w as typed
      return f;
   endfunction : match_frame

   // ------------------------------------------------------------
   // register storage and bus state
   // ------------------------------------------------------------
   logic [31:0] cfg [0:7];
   logic aw_full;
   logic w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   state_t state;
   state_t next_state;
   logic [7:0] left;
   logic [7:0] next_left;
   logic [4:0] bitcnt;
   logic [4:0] hunt_bits;
   logic [SHR_W-1:0] shr;
   logic lc_s1, lc_s2, lc_prev;
   logic ld_s1, ld_s2;
   logic rel;
   logic trig;
   logic emit;
   logic chk;
   logic drain_chk;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire do_write = aw_full && w_full && !s_axi_bvalid;
   wire [2:0] widx = aw_addr[4:2];
   wire [2:0] ridx = s_axi_araddr[4:2];
   wire w_bad = (widx == `IDX_STATUS) || (aw_addr[1:0] != 2'h0);
   wire r_bad = s_axi_araddr[1:0] != 2'h0;
   wire ar_take = s_axi_arvalid && s_axi_arready;
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // ------------------------------------------------------------
   // configuration fields
   // ------------------------------------------------------------
   wire [31:0] ctrl = cfg[`IDX_CTRL];
   wire mode_t mode = mode_t'(ctrl[`F_MODE]);
   wire parity_t par = parity_t'(ctrl[`F_PAR]);
   wire [3:0] w = `MIN_W + {2'h0, ctrl[`F_CODE]};
   wire has_par = par != PAR_NONE;
   // frame length from code and parity
   wire [3:0] flen = w + {3'h0, has_par};
   wire [8:0] fmask = 9'h1ff >> (4'h9 - flen);
   wire errchk = ctrl[`F_ERRCHK];
   wire mono = mode == MODE_MONO;
   wire sync_mode = (mode == MODE_SYNC) || mono;
   wire [6:0] dmask = cfg[`IDX_DROPB][`F_DMASK];
   wire [7:0] drop_n = cfg[`IDX_LIMIT][15:8];
   wire [1:0] bcc_len = ctrl[`F_BCC];
   wire keep_all = (drop_n == 8'h0) && (dmask == 7'h0);

   // shift only for LSB first without suppress
   wire [2:0] shift = ctrl[`F_SHIFT];
   wire shift_ok = !ctrl[`F_MSB] && !ctrl[`F_SUPP];
   // shift bounded by data width, skips parity
   wire [4:0] s_eff = (shift_ok && {1'b0, shift} < w) ?
      {2'h0, shift} : 5'h0;

   // ------------------------------------------------------------
   // sync pattern and hunt compare
   // ------------------------------------------------------------
   wire [7:0] sync1 = cfg[`IDX_SYNC][7:0];
   wire [7:0] sync2 = cfg[`IDX_SYNC][15:8];
   wire [8:0] f1 = ctrl[`F_IDLES] ? fmask :
      match_frame(sync1, w, par) & fmask;
   wire [8:0] f2 = ctrl[`F_IDLES] ? fmask :
      match_frame(sync2, w, par) & fmask;
   wire [4:0] nbits = mono ? {1'b0, flen} : {flen, 1'b0};
   wire [17:0] pat = mono ? {9'h0, f1} :
      (({9'h0, f2} << flen) | {9'h0, f1});
   wire [17:0] rxwin = shr >> (5'd18 - nbits);
   // at most the last 16 bits take part
   wire [4:0] cmpl = (nbits > `SYNC_CMP_BITS) ?
      `SYNC_CMP_BITS : nbits;
   wire [17:0] cmask = ((18'h1 << cmpl) - 18'h1) << (nbits - cmpl);
   wire sync_hit = (((rxwin ^ pat) & cmask) == 18'h0) &&
      (hunt_bits >= nbits);

   // ------------------------------------------------------------
   // received character and list compares
   // ------------------------------------------------------------
   wire bit_stb = lc_s2 && !lc_prev;
   // frame taken from the shift in flight, so its last bit counts
   wire [SHR_W-1:0] shr_in = {ld_s2, shr[SHR_W-1:1]};
   wire [8:0] fr = 9'(shr_in >> (5'd18 - {1'b0, flen}));
   wire is_idle = fr == fmask;
   wire char_done = (state != ST_HUNT) && bit_stb && (bitcnt == 5'h1);
   wire [7:0] lst [0:11];
   wire [11:0] hit;
   assign lst[0] = cfg[`IDX_DROPA][7:0];
   assign lst[1] = cfg[`IDX_DROPA][15:8];
   assign lst[2] = cfg[`IDX_DROPA][23:16];
   assign lst[3] = cfg[`IDX_DROPA][31:24];
   assign lst[4] = cfg[`IDX_DROPB][7:0];
   assign lst[5] = cfg[`IDX_DROPB][15:8];
   assign lst[6] = cfg[`IDX_DROPB][23:16];
   assign lst[7] = cfg[`IDX_STOP][7:0];
   assign lst[8] = cfg[`IDX_STOP][15:8];
   assign lst[9] = cfg[`IDX_STOP][23:16];
   assign lst[10] = cfg[`IDX_STOP][31:24];
   assign lst[11] = cfg[`IDX_LIMIT][7:0];
   // one comparator per programmed match character
   for (genvar i = 0; i < 12; i++) begin : g_cmp
      assign hit[i] = fr == (match_frame(lst[i], w, par) & fmask);
   end
   // slot 0 within text, slots 1..6 outside
   wire within_hit = hit[0] && dmask[0];
   wire out_hit = |(hit[6:1] & dmask[6:1]);
   wire [3:0] stop_hit = hit[10:7];
   wire start_hit = hit[11];

   // ------------------------------------------------------------
   // transmit framing of the test character
   // ------------------------------------------------------------
   wire [7:0] tx_c = cfg[`IDX_TXCHR][7:0] & (8'hff >> (4'h8 - w));
   logic tx_pb;
   always_comb begin
      tx_pb = 1'b0;
      unique case (par)
         PAR_EVEN: tx_pb = ^tx_c;
         PAR_ODD: tx_pb = ~^tx_c;
         // ignore gives zero, or odd for 8-bit
         PAR_IGNORE: tx_pb = (w == `FULL_W) ? ~^tx_c : 1'b0;
         PAR_NONE: tx_pb = 1'b0;
      endcase
   end
   wire [8:0] tx_frame = {1'b0, tx_c} |
      (has_par ? ({8'h0, tx_pb} << w) : 9'h0);

   // ------------------------------------------------------------
   // framer next state, evaluated per received character
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_left = left;
      trig = 1'b0;
      rel = 1'b0;
      emit = 1'b1;
      chk = 1'b0;
      unique case (state)
         ST_HUNT: begin
            emit = 1'b0;
         end
         ST_OUTSIDE: begin
            emit = !is_idle || keep_all;
            // checking off keeps us outside text
            if (errchk && start_hit) begin
               next_state = ST_INTEXT;
            end else if (out_hit) begin
               trig = 1'b1;
            end
         end
         ST_INTEXT: begin
            chk = 1'b1;
            // within char only inside the limits
            if (within_hit) begin
               trig = 1'b1;
            end else if (stop_hit[3]) begin
               next_state = ST_OUTSIDE;
            end else if (|stop_hit[2:0]) begin
               if (bcc_len == 2'h0) begin
                  trig = !keep_all;
                  next_state = ST_OUTSIDE;
               end else begin
                  next_state = ST_BCC;
                  next_left = {6'h0, bcc_len};
               end
            end
         end
         ST_BCC: begin
            next_left = left - 8'h1;
            if (left == 8'h1) begin
               next_state = ST_OUTSIDE;
               trig = !keep_all;
            end
         end
         ST_DRAIN: begin
            chk = drain_chk;
            next_left = left - 8'h1;
            if (left == 8'h1) begin
               rel = 1'b1;
            end
         end
         default: begin
            next_state = ST_HUNT;
         end
      endcase
      // zero releases now, else count N chars
      if (trig) begin
         if (drop_n == 8'h0) begin
            rel = 1'b1;
         end else begin
            next_state = ST_DRAIN;
            next_left = drop_n;
         end
      end
      // release sends us back to hunting
      if (rel) begin
         next_state = ST_HUNT;
      end
   end

   // ------------------------------------------------------------
   // line pin synchronisers
   // ------------------------------------------------------------
   // two flops each; the line clock is only sampled
   always_ff @(posedge clk) begin
      lc_s1 <= line_clk;
      lc_s2 <= lc_s1;
      lc_prev <= lc_s2;
      ld_s1 <= line_data;
      ld_s2 <= ld_s1;
   end

   // ------------------------------------------------------------
   // bit shifter, bit counter and hunt
   // ------------------------------------------------------------
   // bits arrive least significant first, newest at the top
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shr <= '0;
      end else if (bit_stb) begin
         shr <= shr_in;
      end
   end

   // hunt_bits stops a stale window matching right after a drop
   always_ff @(posedge clk) begin
      if (sys_rst || state != ST_HUNT) begin
         hunt_bits <= 5'h0;
      end else if (bit_stb && hunt_bits != 5'h1f) begin
         hunt_bits <= hunt_bits + 5'h1;
      end
   end

   // alignment starts from a sync match over at most the last 16 bits
   always_ff @(posedge clk) begin
      if (sys_rst || !sync_mode) begin
         state <= ST_HUNT;
         left <= 8'h0;
      end else if (state == ST_HUNT && sync_hit) begin
         state <= ST_OUTSIDE;
      end else if (char_done) begin
         state <= next_state;
         left <= next_left;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || state == ST_HUNT) begin
         drain_chk <= 1'b0;
      end else if (char_done && state != ST_DRAIN) begin
         drain_chk <= chk;
      end
   end

   // first frame may be stretched by the realign shift
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bitcnt <= 5'h0;
      end else if (state == ST_HUNT) begin
         bitcnt <= {1'b0, flen} + s_eff;
      end else if (char_done) begin
         bitcnt <= {1'b0, flen};
      end else if (bit_stb) begin
         bitcnt <= bitcnt - 5'h1;
      end
   end

   // ------------------------------------------------------------
   // capture outputs
   // ------------------------------------------------------------
   // in-sync level, sync-lost pulse
   assign in_sync = state != ST_HUNT;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         char_data <= 9'h0;
         char_valid <= 1'b0;
         char_checked <= 1'b0;
         sync_lost <= 1'b0;
      end else begin
         char_valid <= char_done && emit;
         sync_lost <= char_done && rel;
         if (char_done) begin
            char_data <= fr;
            char_checked <= chk;
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   // address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_full <= 1'b0;
         end
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= w_bad ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // byte-lane writes; status word is read only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int r = 0; r < 8; r++) begin
            cfg[r] <= (r == 0) ? `CTRL_RST : 32'h0;
         end
      end else if (do_write && !w_bad) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
               cfg[widx][8*b +: 8] <= w_data[8*b +: 8];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   wire [31:0] status = {28'h0, state, in_sync};
   wire [31:0] rd_word = (ridx == `IDX_STATUS) ? status :
      (ridx == `IDX_TXCHR) ? {23'h0, tx_frame} : cfg[ridx];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= r_bad ? 32'h0 : rd_word;
         s_axi_rresp <= r_bad ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : char_sync_hunt_drop

// ### char_sync_properties.sv
// concurrent checks on the sync receiver's top-level ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module char_sync_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic char_valid,
   input wire logic in_sync,
   input wire logic sync_lost
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // line side
   // ----------------------------------------
   // a new sync needs whole bit times, so hunt lasts
   sequence s_hunting;
      !in_sync [*4];
   endsequence
   a_lost_pulse: assert property (sync_lost |=> !sync_lost)
      else $error("sync lost longer than one cycle");
   a_drop_to_hunt: assert property (sync_lost |-> ##[0:1] s_hunting)
      else $error("still aligned after sync lost");
   a_fall_has_cause: assert property ($fell(in_sync) |-> sync_lost || $past(sync_lost))
      else $error("alignment fell without sync lost");
   a_char_in_sync: assert property (char_valid |-> $past(in_sync))
      else $error("char captured while hunting");
   a_char_pulse: assert property (char_valid |=> !char_valid)
      else $error("char valid held");
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) // bus
      else $error("write response not held");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // bus
      else $error("read data not held");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // bus
      else $error("write taken with response pending");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) // bus
      else $error("read taken with data pending");
endmodule : char_sync_properties
bind char_sync_hunt_drop char_sync_properties u_props (.clk(clk), .sys_rst(sys_rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .char_valid(char_valid),
   .in_sync(in_sync), .sync_lost(sync_lost));

// ### line_tx.sv
// serial line source standing in for the modem side
// assumes the receiver takes data on the line clock rising edge
`timescale 1ns/100ps
module line_tx (
   output logic line_clk,
   output logic line_data
);
   initial begin
      line_clk = 1'b0;
      line_data = 1'b1;
   end
   // frame bits lsb first
   // clock stands still between calls; data left inverted when idle
   task automatic send(input logic [8:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         line_data = v[i];
         #160 line_clk = 1'b1;
         #160 line_clk = 1'b0;
      end
      line_data = ~v[n-1];
   endtask : send
endmodule : line_tx

// ### tb_char_sync_hunt_drop.sv
// self-checking bench for the character sync receiver
// assumes the line model and the bound property checker
`include "char_sync_defines.svh"
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_char_sync_hunt_drop;
   import char_sync_pkg::*;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [15:0] sreg;
      logic [3:0] flen;
      logic [8:0] s1;
      logic [8:0] s2;
      logic [8:0] dat;
   } row_t;
   // ctrl, sync reg, frame bits, sync frames, data frame = expected
   row_t rows[7] = '{
      '{32'h0c, 16'h1616, 4'h8, 9'h016, 9'h016, 9'h0a5},
      '{32'h01, 16'h0015, 4'h5, 9'h000, 9'h015, 9'h00b},
      '{32'h15, 16'h001a, 4'h7, 9'h000, 9'h01a, 9'h063},
      '{32'h39, 16'h0016, 4'h8, 9'h000, 9'h016, 9'h041},
      '{32'h1c, 16'h3232, 4'h9, 9'h131, 9'h132, 9'h055},
      '{32'h3c, 16'h1616, 4'h9, 9'h017, 9'h016, 9'h141},
      '{32'h8c, 16'h0000, 4'h8, 9'h0ff, 9'h0ff, 9'h03c}};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [4:0] s_axi_araddr = 5'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic line_clk;
   logic line_data;
   logic [8:0] char_data;
   logic char_valid;
   logic char_checked;
   logic in_sync;
   logic sync_lost;
   logic [8:0] gd[$];
   logic gc[$];
   int n_lost;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic [8:0] eq[$];
   logic ec[$];
   always #20 clk = ~clk;
   char_sync_hunt_drop u_char_sync_hunt_drop (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .line_clk(line_clk),
      .line_data(line_data), .char_data(char_data),
      .char_valid(char_valid), .char_checked(char_checked),
      .in_sync(in_sync), .sync_lost(sync_lost));
   line_tx u_line_tx (.line_clk(line_clk), .line_data(line_data));
   // ----------------------------------------
   // capture monitor and bus tasks
   // ----------------------------------------
   // pulses are collected so long messages need no cycle bookkeeping
   always @(posedge clk) begin
      if (char_valid) begin
         gd.push_back(char_data);
         gc.push_back(char_checked);
      end
      if (sync_lost) n_lost++;
   end
   task automatic do_reset;
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      gd.delete();
      gc.delete();
      n_lost = 0;
   endtask : do_reset
   // address and data offered together, each released when taken
   task automatic axw(input logic [4:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [4:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #2000000;
      n_mismatch++;
      conclude();
   end
   initial begin
      do_reset();
      axr(5'h00);
      `CHK("ctrl reset", `CTRL_RST, rd)
      axw(5'h18, 32'h1);
      `CHK("status write", `RESP_SLVERR, rsp)
      axr(5'h01);
      `CHK("misaligned read", `RESP_SLVERR, rsp)
      $display("test registers done");
      // framing per code and parity; empty list keeps idles
      foreach (rows[i]) begin
         do_reset();
         axw(5'h00, rows[i].ctrl);
         axw(5'h04, {16'h0, rows[i].sreg});
         axw(5'h1c, {24'h0, rows[i].dat[7:0]});
         axr(5'h1c);
         `CHK("tx frame", {23'h0, rows[i].dat}, rd)
         if (!rows[i].ctrl[0]) u_line_tx.send(rows[i].s1, rows[i].flen);
         u_line_tx.send(rows[i].s2, rows[i].flen);
         u_line_tx.send(rows[i].dat, rows[i].flen);
         u_line_tx.send(9'h1ff, rows[i].flen);
         repeat (12) @(posedge clk);
         `CHK("in sync", 1'b1, in_sync)
         `CHK("rx data", rows[i].dat, gd[0])
         `CHK("rx idle", 9'h1ff >> (9 - rows[i].flen), gd[1])
         $display("test row %0d done", i);
      end
      // async framing never aligns
      do_reset();
      axw(5'h00, 32'h0e);
      axw(5'h04, 32'h1616);
      repeat (9) u_line_tx.send(9'h016, 8);
      repeat (12) @(posedge clk);
      `CHK("async hunt", 1'b0, in_sync)
      `CHK("async none", 0, gd.size())
      $display("test async done");
      // check span, stop list, block check, drop count and within char
      do_reset();
      axw(5'h00, 32'h404c);
      axw(5'h04, 32'h1616);
      axw(5'h08, 32'h5dbb);
      axw(5'h0c, 32'h03000000);
      axw(5'h10, 32'h0102);
      axw(5'h14, 32'h17000003);
      eq = '{9'h016, 9'h016, 9'h0ff, 9'h002, 9'h05d, 9'h017, 9'h002,
         9'h042, 9'h003, 9'h0c1, 9'h0c2, 9'h099, 9'h077, 9'h016, 9'h016,
         9'h0a5, 9'h002, 9'h0bb, 9'h055, 9'h066};
      foreach (eq[i]) u_line_tx.send(eq[i], 8);
      repeat (12) @(posedge clk);
      eq = '{9'h002, 9'h05d, 9'h017, 9'h002, 9'h042, 9'h003, 9'h0c1,
         9'h0c2, 9'h099, 9'h0a5, 9'h002, 9'h0bb, 9'h055};
      ec = '{0, 1, 1, 0, 1, 1, 0, 0, 0, 0, 0, 1, 1};
      `CHK("drop count", eq.size(), gd.size())
      foreach (eq[i]) begin
         `CHK("drop data", eq[i], gd[i])
         `CHK("check span", ec[i], gc[i])
      end
      `CHK("sync lost count", 2, n_lost)
      `CHK("hunting", 1'b0, in_sync)
      axr(5'h18);
      `CHK("status hunt", 32'h0, rd)
      $display("test drop done");
      conclude();
   end
endmodule : tb_char_sync_hunt_drop
